// >>> dtt_top.sv
// toggle mode and thermal shutdown control with an AXI4-Lite register slave
//
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps

// What this block does
// - command with both select bits zero and address 1100 writes the control register
// - toggle enabled per group of eight by two control bits, position per variant
// - every channel holds a full-width A and B data register
// - B register loads only while its group has toggle enabled
// - each load strobe in toggle alternates the DAC source between A and B
// - first load after toggle is configured copies the A registers
// - toggle turned off by control register; next load copies A registers
// - thermal protection acts only while its control enable bit is set
// - with protection on, overtemperature powers down all output amplifiers
// - shutdown holds until soft power-up while cool, or protection disabled
module dtt_top import dtt_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // load strobe and temperature flag
  input wire logic load_dac_strobe_n_i,
  input wire logic overtemp_i,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // converter side
  output logic [NUM_CH*CODE_W-1:0] dac_codes_o,
  output logic [NUM_GRP-1:0] toggle_phase_o,
  output logic amp_power_down_o,
  output logic irq_o
);

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] last_cmd;
    logic [CTRL_W-1:0] ctrl;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic irq;
    dtt_therm_t th;
    logic amp_pd;
    logic ld_prev;
    logic ld_pulse;
    logic bwr_en;
    logic bwr_b;
    logic [3:0] bwr_ch;
    logic [CODE_W-1:0] bwr_data;
  } dtt_top_state_t;

  localparam dtt_top_state_t STATE_RST = '{
    awready: 1'b1, wready: 1'b1, aw_got: 1'b0, w_got: 1'b0, awaddr: 8'h00,
    wdata: WORD_ZERO, wstrb: 4'h0, bvalid: 1'b0, bresp: RESP_OKAY,
    arready: 1'b1, rvalid: 1'b0, rdata: WORD_ZERO, rresp: RESP_OKAY,
    last_cmd: WORD_ZERO, ctrl: CTRL_RST, status: EV_RST, mask: EV_RST, irq: 1'b0,
    th: TH_RUN, amp_pd: 1'b0, ld_prev: 1'b1, ld_pulse: 1'b0,
    bwr_en: 1'b0, bwr_b: 1'b0, bwr_ch: 4'h0, bwr_data: 14'h0000
  };

  dtt_top_state_t q;
  dtt_top_state_t d;

  // write, load and toggle path to the channel bank
  dtt_bank_if bif();

  logic exec;
  logic cmd_exec;
  logic soft_pwrup;
  logic th_en;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] w1c;
  logic [31:0] rd;
  logic [NUM_GRP-1:0] tog_now;

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    d = q;
    ev = '0;
    w1c = '0;
    rd = WORD_ZERO;
    // decoded from the current control word
    tog_now = tog_enables(q.ctrl);
    th_en = therm_enable(q.ctrl);

    // write channels are accepted in either order and held until both are in
    if (s_axi_awvalid_i && q.awready) begin
      d.aw_got = 1'b1;
      d.awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && q.wready) begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata_i;
      d.wstrb = s_axi_wstrb_i;
    end
    // a write runs once both halves are in and no response is pending
    exec = q.aw_got && q.w_got && !q.bvalid;
    cmd_exec = exec && (q.awaddr == OFS_CMD);
    soft_pwrup = exec && (q.awaddr == OFS_PWRUP) && q.wstrb[0] && q.wdata[PWRUP_BIT];
    if (exec) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = reg_mapped(q.awaddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (q.bvalid && s_axi_bready_i) begin
      d.bvalid = 1'b0;
    end
    // each write channel stays closed until its response has been taken
    d.awready = !d.aw_got && !d.bvalid;
    d.wready = !d.w_got && !d.bvalid;

    // command word: control register or a channel data register
    d.bwr_en = 1'b0;
    if (cmd_exec) begin
      d.last_cmd = q.wdata;
      if (is_ctrl_write(q.wdata)) begin
        d.ctrl = q.wdata[CTRL_W-1:0];
      end else if (reg_select(q.wdata) == SEL_DATA_A || reg_select(q.wdata) == SEL_DATA_B) begin
        d.bwr_en = 1'b1;
        d.bwr_b = (reg_select(q.wdata) == SEL_DATA_B);
        d.bwr_ch = target_address_field(q.wdata);
        d.bwr_data = q.wdata[CODE_W-1:0];
        // a refused B write is flagged so software can see the setup order slipped
        ev[EV_BREFUSE] = d.bwr_b && !tog_now[d.bwr_ch[3]];
      end
    end

    // mask and write-one-to-clear status honour the low byte lane
    if (exec && (q.awaddr == OFS_MASK) && q.wstrb[0]) begin
      d.mask = q.wdata[EV_W-1:0];
    end
    if (exec && (q.awaddr == OFS_STATUS) && q.wstrb[0]) begin
      w1c = q.wdata[EV_W-1:0];
    end

    // load strobe falling edge becomes a one-cycle load pulse to the bank
    d.ld_prev = load_dac_strobe_n_i;
    d.ld_pulse = q.ld_prev && !load_dac_strobe_n_i;
    ev[EV_LOAD] = q.ld_pulse;

    // thermal shutdown latch
    case (q.th)
      TH_RUN: begin
        if (th_en && overtemp_i) begin
          d.th = TH_SHUT;
        end
      end
      TH_SHUT: begin
        if (!th_en || (soft_pwrup && !overtemp_i)) begin
          d.th = TH_RUN;
        end
      end
      default: begin
        d.th = TH_RUN;
      end
    endcase
    // power-down mirrors the latch; the event marks only its entry
    d.amp_pd = (d.th == TH_SHUT);
    ev[EV_THERM] = (q.th == TH_RUN) && (d.th == TH_SHUT);

    // a new event wins over a clear in the same cycle
    d.status = (q.status & ~w1c) | ev;
    d.irq = |(d.status & d.mask);

    // read channel
    if (s_axi_arvalid_i && q.arready) begin
      case (s_axi_araddr_i)
        OFS_CMD: rd = q.last_cmd;
        OFS_CTRL: rd[CTRL_W-1:0] = q.ctrl;
        OFS_STATUS: rd[EV_W-1:0] = q.status;
        OFS_MASK: rd[EV_W-1:0] = q.mask;
        OFS_STATE: begin
          rd[ST_AMP_PD] = q.amp_pd;
          // live sensor level, not the latch
          rd[ST_OVERTEMP] = overtemp_i;
          rd[ST_PHASE_LSB+:NUM_GRP] = bif.phase;
        end
        default: rd = WORD_ZERO;
      endcase
      d.rvalid = 1'b1;
      d.rdata = rd;
      d.rresp = reg_mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
    end else if (q.rvalid && s_axi_rready_i) begin
      d.rvalid = 1'b0;
    end
    // one read at a time: the address reopens once the data is taken
    d.arready = !d.rvalid;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register

  // clock enable low freezes every flop, bus included
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= STATE_RST;
    end else if (ce_i) begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // channel bank

  // registered requests: a data write reaches the A or B register two edges after exec
  assign bif.wr_en = q.bwr_en;
  assign bif.wr_b = q.bwr_b;
  assign bif.wr_ch = q.bwr_ch;
  assign bif.wr_data = q.bwr_data;
  assign bif.load = q.ld_pulse;
  assign bif.tog_en = tog_enables(q.ctrl);

  dtt_chan_bank u_bank (
    .clk_sys_i (clk_sys_i),
    .nrst_i (nrst_i),
    .ce_i (ce_i),
    .bif (bif)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  // every output is a flop here or in the bank
  assign s_axi_awready_o = q.awready;
  assign s_axi_wready_o = q.wready;
  assign s_axi_bresp_o = q.bresp;
  assign s_axi_bvalid_o = q.bvalid;
  assign s_axi_arready_o = q.arready;
  assign s_axi_rdata_o = q.rdata;
  assign s_axi_rresp_o = q.rresp;
  assign s_axi_rvalid_o = q.rvalid;
  assign dac_codes_o = bif.dac;
  assign toggle_phase_o = bif.phase;
  assign amp_power_down_o = q.amp_pd;
  assign irq_o = q.irq;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  // control register and toggle enables
  chk_ctrl_decode: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ce_i && cmd_exec && is_ctrl_write(q.wdata) |=> q.ctrl == $past(q.wdata[CTRL_W-1:0]))
    else $error("control write not decoded");

  chk_ctrl_ignored: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ce_i && !(cmd_exec && is_ctrl_write(q.wdata)) |=> $stable(q.ctrl))
    else $error("control register changed without its command");

  chk_toggle_bits: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ce_i && cmd_exec && is_ctrl_write(q.wdata)
    |=> bif.tog_en == {$past(q.wdata[TOGGLE_GROUP_HI_EN]), $past(q.wdata[TOGGLE_GROUP_LO_EN])})
    else $error("toggle enables not taken from the control bits");

  chk_refuse_event: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ce_i && cmd_exec && (reg_select(q.wdata) == SEL_DATA_B)
    && !bif.tog_en[q.wdata[TARGET_ADDRESS_LSB+3]] |=> q.status[EV_BREFUSE])
    else $error("refused B write not flagged");

  // thermal latch
  chk_thermal_gate: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ce_i && !th_en |=> !amp_power_down_o)
    else $error("amplifiers down while protection disabled");

  chk_thermal_trip: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ce_i && th_en && overtemp_i
    |=> amp_power_down_o && (q.status[EV_THERM] || $past(amp_power_down_o)))
    else $error("overtemperature did not power down amplifiers");

  chk_hold_shut: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ce_i && amp_power_down_o && th_en && !(soft_pwrup && !overtemp_i) |=> amp_power_down_o)
    else $error("shutdown released without a release condition");

  chk_release: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ce_i && amp_power_down_o && soft_pwrup && !overtemp_i |=> !amp_power_down_o)
    else $error("soft power-up did not release shutdown");

  // load strobe, interrupt and clock enable
  chk_load_pulse: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ce_i && $fell(load_dac_strobe_n_i) && $past(ce_i) |=> bif.load ##1 !bif.load)
    else $error("load strobe edge not turned into one pulse");

  chk_load_event: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ce_i && q.ld_pulse
    |=> q.status[EV_LOAD])
    else $error("load event not flagged");

  chk_irq_level: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ce_i ##1 1'b1 |-> irq_o == |(q.status & q.mask))
    else $error("interrupt does not follow unmasked status");

  chk_ce_freeze: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    !ce_i
    |=> $stable(q))
    else $error("state moved while clock enable low");

  // bus handshakes
  chk_write_answer: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ce_i && exec
    |=> s_axi_bvalid_o && !s_axi_awready_o && !s_axi_wready_o)
    else $error("write response missing");

  chk_write_closed: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    s_axi_bvalid_o
    |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write channels open during response");

  chk_read_answer: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ce_i && s_axi_arvalid_i && s_axi_arready_o
    |=> s_axi_rvalid_o)
    else $error("read data missing");

  chk_read_closed: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    s_axi_rvalid_o
    |-> !s_axi_arready_o)
    else $error("read address open during read data");

endmodule // dtt_top

// >>> dtt_pkg.sv
// shared constants, types and decode functions of the toggle and thermal control block
package dtt_pkg;

  localparam int NUM_CH = 16;
  localparam int CODE_W = 14;
  localparam int NUM_GRP = 2;
  localparam int GRP_SIZE = 8;
  localparam bit VARIANT_12B = 1'b0;

  // control register
  localparam int CTRL_W = 14;
  localparam logic [CTRL_W-1:0] CTRL_RST = 14'h0000;
  localparam int TOGGLE_GROUP_HI_EN = 3;
  localparam int TOGGLE_GROUP_LO_EN = 2;
  localparam int TOGGLE_GROUP_HI_EN_12B = 1;
  localparam int TOGGLE_GROUP_LO_EN_12B = 0;
  localparam int THERMAL_PROTECT_EN = 8;
  localparam int THERMAL_PROTECT_EN_12B = 6;

  // command word fields
  localparam int REG_SELECT_HI = 21;
  localparam int REG_SELECT_LO = 20;
  localparam int TARGET_ADDRESS_LSB = 16;
  localparam int TARGET_ADDRESS_W = 4;
  localparam logic [1:0] SEL_SPECIAL = 2'h0;
  localparam logic [1:0] SEL_DATA_B = 2'h2;
  localparam logic [1:0] SEL_DATA_A = 2'h3;
  localparam logic [3:0] SPECIAL_FUNCTION_REG_CTRL = 4'hc;

  // register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0c;
  localparam logic [7:0] OFS_STATE = 8'h10;
  localparam logic [7:0] OFS_PWRUP = 8'h14;
  localparam int PWRUP_BIT = 0;

  // event bits of status and mask
  localparam int EV_W = 3;
  localparam int EV_THERM = 0;
  localparam int EV_LOAD = 1;
  localparam int EV_BREFUSE = 2;
  localparam logic [EV_W-1:0] EV_RST = 3'h0;

  // state register bits
  localparam int ST_AMP_PD = 0;
  localparam int ST_OVERTEMP = 1;
  localparam int ST_PHASE_LSB = 2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {TH_RUN = 2'b00, TH_SHUT = 2'b01} dtt_therm_t;
  typedef logic [NUM_CH-1:0][CODE_W-1:0] dtt_codes_t;

  function automatic logic [NUM_GRP-1:0] tog_enables(input logic [CTRL_W-1:0] c);
    if (VARIANT_12B) begin
      return {c[TOGGLE_GROUP_HI_EN_12B], c[TOGGLE_GROUP_LO_EN_12B]};
    end
    return {c[TOGGLE_GROUP_HI_EN], c[TOGGLE_GROUP_LO_EN]};
  endfunction

  function automatic logic therm_enable(input logic [CTRL_W-1:0] c);
    return VARIANT_12B ? c[THERMAL_PROTECT_EN_12B] : c[THERMAL_PROTECT_EN];
  endfunction

  function automatic logic [1:0] reg_select(input logic [31:0] w);
    return w[REG_SELECT_HI:REG_SELECT_LO];
  endfunction

  function automatic logic [3:0] target_address_field(input logic [31:0] w);
    return w[TARGET_ADDRESS_LSB+:TARGET_ADDRESS_W];
  endfunction

  function automatic logic is_ctrl_write(input logic [31:0] w);
    return (reg_select(w) == SEL_SPECIAL) && (target_address_field(w) == SPECIAL_FUNCTION_REG_CTRL);
  endfunction

  function automatic logic reg_mapped(input logic [7:0] a);
    return (a == OFS_CMD) || (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_MASK) ||
           (a == OFS_STATE) || (a == OFS_PWRUP);
  endfunction

endpackage

// >>> dtt_bank_if.sv
// channel bank write, load and toggle signals between control and bank
`timescale 1ns/100ps
interface dtt_bank_if;
  import dtt_pkg::*;
  logic wr_en;
  logic wr_b;
  logic [3:0] wr_ch;
  logic [CODE_W-1:0] wr_data;
  logic load;
  logic [NUM_GRP-1:0] tog_en;
  logic [NUM_GRP-1:0] phase;
  dtt_codes_t dac;
  modport ctl (output wr_en, wr_b, wr_ch, wr_data, load, tog_en, input phase, dac);
  modport bank (input wr_en, wr_b, wr_ch, wr_data, load, tog_en, output phase, dac);
endinterface

// >>> dtt_chan_bank.sv
// per-channel A, B and DAC registers with group toggle phase
`timescale 1ns/100ps
module dtt_chan_bank import dtt_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  dtt_bank_if.bank bif
);

  typedef struct packed {
    dtt_codes_t a;
    dtt_codes_t b;
    dtt_codes_t dac;
    logic [NUM_GRP-1:0] phase;
    logic [NUM_GRP-1:0] en_prev;
  } dtt_bank_state_t;

  dtt_bank_state_t q;
  dtt_bank_state_t d;
  logic [NUM_GRP-1:0] use_b;

  always_comb begin
    d = q;
    use_b = '0;
    if (bif.wr_en) begin
      if (!bif.wr_b) begin
        d.a[bif.wr_ch] = bif.wr_data;
      end else if (bif.tog_en[bif.wr_ch[3]]) begin
        d.b[bif.wr_ch] = bif.wr_data;
      end
    end
    for (int g = 0; g < NUM_GRP; g++) begin
      use_b[g] = bif.tog_en[g] && (bif.tog_en[g] == q.en_prev[g]) && q.phase[g];
      if (bif.tog_en[g] != q.en_prev[g]) begin
        d.phase[g] = 1'b0;
      end else if (bif.load && bif.tog_en[g]) begin
        d.phase[g] = ~q.phase[g];
      end
    end
    d.en_prev = bif.tog_en;
    if (bif.load) begin
      for (int c = 0; c < NUM_CH; c++) begin
        d.dac[c] = use_b[c / GRP_SIZE] ? q.b[c] : q.a[c];
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '0;
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign bif.phase = q.phase;
  assign bif.dac = q.dac;

  chk_a_write: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ce_i && bif.wr_en && !bif.wr_b |=> q.a[$past(bif.wr_ch)] == $past(bif.wr_data))
    else $error("A register did not take its write");
  chk_b_refused: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ce_i && bif.wr_en && bif.wr_b && !bif.tog_en[bif.wr_ch[3]] |=> $stable(q.b))
    else $error("B register loaded while toggle off");
  chk_toggle_flip: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ce_i && bif.load && bif.tog_en[1] && q.en_prev[1] && q.phase[1]
    |=> q.dac[8] == $past(q.b[8]) && !q.phase[1])
    else $error("toggle did not source B then return to A");
  chk_first_load_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ce_i && bif.load && !q.phase[0] |=> q.dac[0] == $past(q.a[0]))
    else $error("load in A phase did not copy A");
  chk_off_loads_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ce_i && bif.load && !bif.tog_en[1] |=> q.dac[15] == $past(q.a[15]) && !q.phase[1])
    else $error("load with toggle off did not copy A");
  chk_phase_reset: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ce_i && (bif.tog_en[0] != q.en_prev[0]) |=> !q.phase[0])
    else $error("toggle phase not reset on enable change");

endmodule // dtt_chan_bank

// >>> dtt_host_model.sv
// host-side model driving the load strobe and the overtemperature flag
`timescale 1ns/100ps
module dtt_host_model (
  input wire logic clk_sys_i,
  output logic load_dac_strobe_n_o,
  output logic overtemp_o
);
  initial begin
    load_dac_strobe_n_o = 1'b1;
    overtemp_o = 1'b0;
  end

  // one load: low for a few cycles, then high samples before the next fall
  task automatic strobe(input int unsigned low_cyc);
    @(posedge clk_sys_i);
    load_dac_strobe_n_o <= 1'b0;
    repeat (low_cyc) @(posedge clk_sys_i);
    load_dac_strobe_n_o <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
  endtask

  // sensor output is one synchronous level
  task automatic set_temp(input logic hot);
    @(posedge clk_sys_i);
    overtemp_o <= hot;
    repeat (3) @(posedge clk_sys_i);
  endtask
endmodule // dtt_host_model

// >>> dtt_top_test.sv
// self-checking bench for the toggle and thermal control block
`timescale 1ns/100ps
module dtt_top_test;
  import dtt_pkg::*;
  logic clk_sys_i, nrst_i, ce, awvalid, wvalid, bready, arvalid, rready;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid, irq, pd, strobe_n, hot;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, phase;
  logic [NUM_CH*CODE_W-1:0] dac;
  logic [1:0] exp_b[$];
  logic [33:0] exp_r[$];
  logic [CODE_W-1:0] a_code[NUM_CH], b_code[NUM_CH];
  int errors, compares;

  dtt_host_model u_host (.clk_sys_i(clk_sys_i), .load_dac_strobe_n_o(strobe_n),
    .overtemp_o(hot));
  dtt_top u_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(ce),
    .load_dac_strobe_n_i(strobe_n), .overtemp_i(hot), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .dac_codes_o(dac), .toggle_phase_o(phase),
    .amp_power_down_o(pd), .irq_o(irq));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [NUM_CH*CODE_W-1:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    if (errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // responses are compared in arrival order against the noted expectations
  always @(posedge clk_sys_i) begin
    if (bvalid && bready) check("bresp", bresp, exp_b.pop_front());
    if (rvalid && rready) check("rdata", {rresp, rdata}, exp_r.pop_front());
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit a_ok, w_ok;
    a_ok = 0;
    w_ok = 0;
    exp_b.push_back(er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    // ready stays high between transfers; only the watchdog ends a wait
    bready <= 1'b1;
    while (!(a_ok && w_ok)) begin
      @(posedge clk_sys_i);
      if (awvalid && awready) begin
        a_ok = 1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_ok = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk_sys_i); while (!bvalid);
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed);
    exp_r.push_back({er, ed});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_sys_i); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk_sys_i); while (!rvalid);
  endtask

  function automatic logic [31:0] cmd(input logic [1:0] s, input logic [3:0] ad,
                                      input logic [13:0] d);
    return {10'h000, s, ad, 2'b00, d};
  endfunction

  task automatic set_ctrl(input logic [13:0] v);
    wr(OFS_CMD, cmd(SEL_SPECIAL, SPECIAL_FUNCTION_REG_CTRL, v), RESP_OKAY);
    repeat (2) @(posedge clk_sys_i);
  endtask

  function automatic logic [NUM_CH*CODE_W-1:0] exp_dac(input logic [1:0] use_b);
    logic [NUM_CH*CODE_W-1:0] v;
    for (int c = 0; c < NUM_CH; c++) begin
      v[c*CODE_W+:CODE_W] = use_b[c/GRP_SIZE] ? b_code[c] : a_code[c];
    end
    return v;
  endfunction

  task automatic pulse(input logic [1:0] use_b, input logic [1:0] ph);
    u_host.strobe($urandom_range(3, 1));
    check("dac_codes", dac, exp_dac(use_b));
    check("phase", phase, ph);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  initial begin
    #200_000;
    errors++;
    final_report();
  end

  initial begin
    void'($urandom(32'h0000_cbe0));
    {nrst_i, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    ce = 1'b1;
    wstrb = 4'hf;
    errors = 0;
    compares = 0;
    repeat (10) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    @(posedge clk_sys_i);
    check("irq", irq, 1'b0);
    check("dac_codes", dac, '0);
    rd(OFS_CTRL, RESP_OKAY, WORD_ZERO);
    rd(OFS_STATUS, RESP_OKAY, WORD_ZERO);
    rd(OFS_PWRUP, RESP_OKAY, WORD_ZERO);
    rd(8'h18, RESP_SLVERR, WORD_ZERO);
    wr(8'h1c, 32'h0000_0001, RESP_SLVERR);
    wr(OFS_MASK, 32'h0000_0001, RESP_OKAY);
    rd(OFS_MASK, RESP_OKAY, 32'h0000_0001);
    wr(OFS_CMD, cmd(SEL_DATA_B, 4'h3, 14'h1abc), RESP_OKAY);
    rd(OFS_STATUS, RESP_OKAY, 32'h0000_0004);
    check("irq", irq, 1'b0);
    wr(OFS_STATUS, 32'h0000_0004, RESP_OKAY);
    rd(OFS_STATUS, RESP_OKAY, WORD_ZERO);
    wr(OFS_CMD, cmd(SEL_SPECIAL, 4'hd, 14'h010c), RESP_OKAY);
    rd(OFS_CTRL, RESP_OKAY, WORD_ZERO);
    set_ctrl(14'h000c);
    rd(OFS_CTRL, RESP_OKAY, 32'h0000_000c);
    for (int c = 0; c < NUM_CH; c++) begin
      a_code[c] = 14'($urandom);
      wr(OFS_CMD, cmd(SEL_DATA_A, 4'(c), a_code[c]), RESP_OKAY);
    end
    for (int c = 0; c < NUM_CH; c++) begin
      b_code[c] = 14'($urandom);
      wr(OFS_CMD, cmd(SEL_DATA_B, 4'(c), b_code[c]), RESP_OKAY);
    end
    rd(OFS_STATUS, RESP_OKAY, WORD_ZERO);
    pulse(2'b00, 2'b11);
    pulse(2'b11, 2'b00);
    pulse(2'b00, 2'b11);
    // a whole strobe while the clock enable is low must not load
    ce <= 1'b0;
    u_host.strobe(1);
    ce <= 1'b1;
    check("dac_codes", dac, exp_dac(2'b00));
    check("phase", phase, 2'b11);
    set_ctrl(14'h0008);
    check("phase", phase, 2'b10);
    wr(OFS_CMD, cmd(SEL_DATA_B, 4'h2, 14'h0123), RESP_OKAY);
    b_code[9] = 14'h2345;
    wr(OFS_CMD, cmd(SEL_DATA_B, 4'h9, b_code[9]), RESP_OKAY);
    rd(OFS_STATUS, RESP_OKAY, 32'h0000_0006);
    pulse(2'b10, 2'b00);
    set_ctrl(14'h0000);
    pulse(2'b00, 2'b00);
    wr(OFS_STATUS, 32'h0000_0007, RESP_OKAY);
    u_host.set_temp(1'b1);
    check("amp_pd", pd, 1'b0);
    set_ctrl(14'h0100);
    check("amp_pd", pd, 1'b1);
    check("irq", irq, 1'b1);
    rd(OFS_STATE, RESP_OKAY, 32'h0000_0003);
    wr(OFS_PWRUP, 32'h0000_0001, RESP_OKAY);
    repeat (2) @(posedge clk_sys_i);
    check("amp_pd", pd, 1'b1);
    u_host.set_temp(1'b0);
    check("amp_pd", pd, 1'b1);
    wr(OFS_PWRUP, 32'h0000_0001, RESP_OKAY);
    repeat (2) @(posedge clk_sys_i);
    check("amp_pd", pd, 1'b0);
    u_host.set_temp(1'b1);
    check("amp_pd", pd, 1'b1);
    set_ctrl(14'h0000);
    check("amp_pd", pd, 1'b0);
    u_host.set_temp(1'b0);
    wstrb <= 4'he;
    wr(OFS_MASK, 32'h0000_0000, RESP_OKAY);
    wstrb <= 4'hf;
    rd(OFS_MASK, RESP_OKAY, 32'h0000_0001);
    wr(OFS_MASK, 32'h0000_0000, RESP_OKAY);
    repeat (2) @(posedge clk_sys_i);
    check("irq", irq, 1'b0);
    wr(OFS_MASK, 32'h0000_0001, RESP_OKAY);
    repeat (2) @(posedge clk_sys_i);
    check("irq", irq, 1'b1);
    wr(OFS_STATUS, 32'h0000_0001, RESP_OKAY);
    repeat (2) @(posedge clk_sys_i);
    check("irq", irq, 1'b0);
    final_report();
  end
endmodule // dtt_top_test
